// file: design/spfmu_pkg.sv
// serial port package: register map, field positions, states, carriers
// assumes SYS_CLK is the oscillator clock and an AXI4-Lite master
package spfmu_pkg;
  localparam logic [7:0] SERIAL_CONTROL_REG_OFF = 8'h00;
  localparam logic [7:0] SERIAL_BUFFER_OFF = 8'h04;
  localparam logic [7:0] POWER_CONTROL_REG_OFF = 8'h08;
  localparam logic [7:0] TIMER2_CONTROL_REG_OFF = 8'h0c;
  localparam logic [7:0] T2CNT_OFF = 8'h10;
  localparam logic [7:0] T2RLD_OFF = 8'h14;
  localparam int SC_RI = 0;
  localparam int SC_TI = 1;
  localparam int SC_RB8 = 2;
  localparam int SC_TB8 = 3;
  localparam int SC_REN = 4;
  localparam int SC_SM2 = 5;
  localparam int SC_MODE = 6;
  localparam int PC_BAUD_DOUBLE = 7;
  localparam int T2_RUN = 2;
  localparam int T2_EXEN = 3;
  localparam int T2_TX_CLK_SEL_TIMER2 = 4;
  localparam int T2_RCLK = 5;
  localparam int T2_EXF = 6;
  localparam int T2_TF = 7;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [3:0] PH_LAST = 4'hb;
  localparam logic [3:0] PH_CLK_LO = 4'h4;
  localparam logic [3:0] PH_CLK_HI = 4'h9;
  localparam logic [3:0] PH_SAMPLE = 4'h9;
  localparam logic [3:0] DIV_S7 = 4'h6;
  localparam logic [3:0] DIV_S8 = 4'h7;
  localparam logic [3:0] DIV_S9 = 4'h8;
  localparam logic [7:0] M0_RX_INIT = 8'hfe;
  localparam logic [8:0] ASY_RX_INIT = 9'h1ff;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {TX_IDLE, TX_REQ, TX_START, TX_DATA, TX_M0_WR, TX_M0_ARM, TX_M0_SEND,
    TX_M0_END} spfmu_txs_t;
  typedef enum logic [2:0] {RX_HUNT, RX_BITS, RX_WAIT, RX_M0_ARM, RX_M0_GO, RX_M0, RX_M0_END} spfmu_rxs_t;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } spfmu_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } spfmu_axi_rsp_t;
  typedef struct packed {
    spfmu_axi_rsp_t rsp; logic aw_hold; logic [7:0] aw_addr; logic w_hold; logic [31:0] w_data;
    logic [3:0] w_strb; logic [7:0] serial_control_reg; logic [7:0] serial_buffer; logic [7:0] power_control_reg; logic [7:0] timer2_control_reg;
    logic [15:0] t2cnt; logic [15:0] t2rld; logic [3:0] phase; logic [1:0] pre; logic t1half;
    logic timer2_ext_pin_prev; spfmu_txs_t tx_st; logic [8:0] tx_sh; logic [3:0] tx_div; logic tx_first;
    spfmu_rxs_t rx_st; logic [8:0] rx_sh; logic [3:0] rx_div; logic rx_prev; logic [1:0] smp;
    logic txd; logic rxd_o; logic rxd_oe;
  } spfmu_st_t;
endpackage

// file: design/spfmu_top.sv
// four-mode serial port with timer 2 baud generator, AXI4-Lite registers
// assumes synchronous pins, one 100 MHz clock, timer 1 overflow as a pulse
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module spfmu_top (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // register bus
  input wire spfmu_pkg::spfmu_axi_req_t AXI_REQ,
  output spfmu_pkg::spfmu_axi_rsp_t AXI_RSP,
  // serial pins
  input wire logic RXD_IN,
  output logic RXD_OUT,
  output logic RXD_OE,
  output logic TXD_OUT,
  // timer pins
  input wire logic TIMER2_EXT_PIN_IN,
  input wire logic T1_OVF_IN
);
  import spfmu_pkg::*;

  spfmu_st_t s_q;
  spfmu_st_t s_d;
  logic [1:0] mode;
  logic m0;
  logic [7:0] wb;
  logic wr_go;
  logic serial_control_reg_wr;
  logic serial_buffer_wr;
  logic timer2_control_reg_wr;
  logic cnt_wr;
  logic rld_wr;
  logic s6p2;
  logic t2_baud;
  logic t2_inc;
  logic t2_ovf;
  logic timer2_ext_pin_fall;
  logic m2_tick;
  logic t1_tick;
  logic tx_tick;
  logic tx_roll;
  logic rx_tick;
  logic vote_now;
  logic vote;
  logic rx_final;
  logic [8:0] rx_new;
  logic m0_act;

  function automatic logic hit(input logic [7:0] a);
    return a inside {SERIAL_CONTROL_REG_OFF, SERIAL_BUFFER_OFF, POWER_CONTROL_REG_OFF, TIMER2_CONTROL_REG_OFF, T2CNT_OFF, T2RLD_OFF};
  endfunction

  function automatic logic [7:0] bitrev(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  always_comb
  begin
    s_d = s_q;
    mode = s_q.serial_control_reg[SC_MODE +: 2];
    m0 = mode == 2'h0;
    wb = s_q.w_data[7:0];
    // bus write: address and data taken in either order
    if (AXI_REQ.awvalid && s_q.rsp.awready)
    begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && s_q.rsp.wready)
    begin
      s_d.w_hold = 1'b1;
      s_d.w_data = AXI_REQ.wdata;
      s_d.w_strb = AXI_REQ.wstrb;
    end
    wr_go = s_q.aw_hold && s_q.w_hold && !s_q.rsp.bvalid;
    if (wr_go)
    begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = hit(s_q.aw_addr) ? RESP_OK : RESP_ERR;
    end
    else if (s_q.rsp.bvalid && AXI_REQ.bready)
    begin
      s_d.rsp.bvalid = 1'b0;
    end
    s_d.rsp.awready = !s_d.aw_hold;
    s_d.rsp.wready = !s_d.w_hold;
    serial_control_reg_wr = wr_go && s_q.w_strb[0] && s_q.aw_addr == SERIAL_CONTROL_REG_OFF;
    serial_buffer_wr = wr_go && s_q.w_strb[0] && s_q.aw_addr == SERIAL_BUFFER_OFF;
    timer2_control_reg_wr = wr_go && s_q.w_strb[0] && s_q.aw_addr == TIMER2_CONTROL_REG_OFF;
    cnt_wr = wr_go && s_q.aw_addr == T2CNT_OFF;
    rld_wr = wr_go && s_q.aw_addr == T2RLD_OFF;
    // bus read: no read side effects
    if (AXI_REQ.arvalid && s_q.rsp.arready)
    begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp = hit(AXI_REQ.araddr) ? RESP_OK : RESP_ERR;
      s_d.rsp.rdata = '0;
      unique case (AXI_REQ.araddr)
        SERIAL_CONTROL_REG_OFF: s_d.rsp.rdata[7:0] = s_q.serial_control_reg;
        SERIAL_BUFFER_OFF: s_d.rsp.rdata[7:0] = s_q.serial_buffer;
        POWER_CONTROL_REG_OFF: s_d.rsp.rdata[7:0] = s_q.power_control_reg;
        TIMER2_CONTROL_REG_OFF: s_d.rsp.rdata[7:0] = s_q.timer2_control_reg;
        T2CNT_OFF: s_d.rsp.rdata[15:0] = s_q.t2cnt;
        T2RLD_OFF: s_d.rsp.rdata[15:0] = s_q.t2rld;
        default: s_d.rsp.rdata = '0;
      endcase
    end
    else if (s_q.rsp.rvalid && AXI_REQ.rready)
    begin
      s_d.rsp.rvalid = 1'b0;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;
    // plain register writes; hardware sets below win over them
    if (serial_control_reg_wr)
    begin
      s_d.serial_control_reg = wb;
    end
    if (wr_go && s_q.w_strb[0] && s_q.aw_addr == POWER_CONTROL_REG_OFF)
    begin
      s_d.power_control_reg = wb;
    end
    if (timer2_control_reg_wr)
    begin
      s_d.timer2_control_reg = wb;
    end
    if (rld_wr && s_q.w_strb[0])
    begin
      s_d.t2rld[7:0] = wb;
    end
    if (rld_wr && s_q.w_strb[1])
    begin
      s_d.t2rld[15:8] = s_q.w_data[15:8];
    end
    // machine cycle of 12 clocks; index 11 is S6P2, 0 is S1P1
    s_d.phase = (s_q.phase == PH_LAST) ? 4'h0 : s_q.phase + 4'h1;
    s6p2 = s_q.phase == PH_LAST;
    // timer 2
    t2_baud = s_q.timer2_control_reg[T2_TX_CLK_SEL_TIMER2] || s_q.timer2_control_reg[T2_RCLK];
    t2_inc = s_q.timer2_control_reg[T2_RUN] && (t2_baud ? s_q.phase[0] : s6p2);
    t2_ovf = t2_inc && s_q.t2cnt == 16'hffff;
    if (t2_inc)
    begin
      s_d.t2cnt = t2_ovf ? s_q.t2rld : s_q.t2cnt + 16'h1;
    end
    if (t2_ovf && !t2_baud)
    begin
      s_d.timer2_control_reg[T2_TF] = 1'b1;
    end
    // count writes while running in baud mode may collide
    if (cnt_wr && s_q.w_strb[0])
    begin
      s_d.t2cnt[7:0] = wb;
    end
    if (cnt_wr && s_q.w_strb[1])
    begin
      s_d.t2cnt[15:8] = s_q.w_data[15:8];
    end
    s_d.timer2_ext_pin_prev = TIMER2_EXT_PIN_IN;
    timer2_ext_pin_fall = s_q.timer2_ext_pin_prev && !TIMER2_EXT_PIN_IN;
    if (timer2_ext_pin_fall && s_q.timer2_control_reg[T2_EXEN])
    begin
      s_d.timer2_control_reg[T2_EXF] = 1'b1;
    end
    // 16x baud clocks
    s_d.pre = s_q.pre + 2'h1;
    m2_tick = s_q.power_control_reg[PC_BAUD_DOUBLE] ? s_q.pre[0] : s_q.pre == 2'h3;
    if (T1_OVF_IN)
    begin
      s_d.t1half = !s_q.t1half;
    end
    t1_tick = T1_OVF_IN && (s_q.power_control_reg[PC_BAUD_DOUBLE] || s_q.t1half);
    tx_tick = (mode == 2'h2) ? m2_tick : (s_q.timer2_control_reg[T2_TX_CLK_SEL_TIMER2] ? t2_ovf : t1_tick);
    rx_tick = (mode == 2'h2) ? m2_tick : (s_q.timer2_control_reg[T2_RCLK] ? t2_ovf : rx_tick_t1(t1_tick));
    if (tx_tick)
    begin
      s_d.tx_div = s_q.tx_div + 4'h1;
    end
    tx_roll = tx_tick && s_q.tx_div == 4'hf;
    // transmitter
    unique case (s_q.tx_st)
      TX_IDLE:
        if (serial_buffer_wr)
        begin
          s_d.tx_sh = {(mode[1] ? s_q.serial_control_reg[SC_TB8] : 1'b1), wb};
          s_d.tx_st = m0 ? TX_M0_WR : TX_REQ;
        end
      TX_M0_WR:
        if (s6p2)
        begin
          s_d.tx_st = TX_M0_ARM;
        end
      TX_M0_ARM:
        if (s6p2)
        begin
          s_d.tx_st = TX_M0_SEND;
        end
      TX_M0_SEND:
        if (s6p2)
        begin
          s_d.tx_sh = {1'b0, s_q.tx_sh[8:1]};
          if (s_q.tx_sh[8:1] == 8'h01)
          begin
            s_d.tx_st = TX_M0_END;
          end
        end
      TX_M0_END:
        if (s_q.phase == 4'h0)
        begin
          s_d.tx_st = TX_IDLE;
          s_d.serial_control_reg[SC_TI] = 1'b1;
        end
      TX_REQ:
        if (tx_roll)
        begin
          s_d.tx_st = TX_START;
          s_d.tx_first = 1'b1;
        end
      TX_START:
        if (tx_roll)
        begin
          s_d.tx_st = TX_DATA;
        end
      TX_DATA:
        if (tx_roll)
        begin
          s_d.tx_sh = {mode[1] && s_q.tx_first, s_q.tx_sh[8:1]};
          s_d.tx_first = 1'b0;
          if (s_q.tx_sh[8:1] == 8'h01)
          begin
            s_d.tx_st = TX_IDLE;
            s_d.serial_control_reg[SC_TI] = 1'b1;
          end
        end
    endcase
    // receiver
    if (rx_tick)
    begin
      s_d.rx_div = s_q.rx_div + 4'h1;
      s_d.rx_prev = RXD_IN;
    end
    if (rx_tick && s_q.rx_div == DIV_S7)
    begin
      s_d.smp[0] = RXD_IN;
    end
    if (rx_tick && s_q.rx_div == DIV_S8)
    begin
      s_d.smp[1] = RXD_IN;
    end
    vote_now = rx_tick && s_q.rx_div == DIV_S9;
    vote = (s_q.smp[0] & s_q.smp[1]) | (s_q.smp[0] & RXD_IN) | (s_q.smp[1] & RXD_IN);
    rx_new = {s_q.rx_sh[7:0], vote};
    rx_final = 1'b0;
    unique case (s_q.rx_st)
      RX_HUNT:
        if (m0)
        begin
          if (s_q.serial_control_reg[SC_REN] && !s_q.serial_control_reg[SC_RI])
          begin
            s_d.rx_st = RX_M0_ARM;
          end
        end
        else if (rx_tick && s_q.serial_control_reg[SC_REN] && s_q.rx_prev && !RXD_IN)
        begin
          s_d.rx_st = RX_BITS;
          s_d.rx_div = 4'h0;
          s_d.rx_sh = ASY_RX_INIT;
        end
      RX_BITS:
        if (vote_now)
        begin
          if (s_q.rx_sh == ASY_RX_INIT && vote)
          begin
            s_d.rx_st = RX_HUNT;
          end
          else
          begin
            s_d.rx_sh = rx_new;
            rx_final = !s_q.rx_sh[8];
            if (rx_final)
            begin
              s_d.rx_st = mode[1] ? RX_WAIT : RX_HUNT;
              if (!s_q.serial_control_reg[SC_RI] && (!s_q.serial_control_reg[SC_SM2] || vote))
              begin
                s_d.serial_buffer = bitrev(rx_new[8:1]);
                s_d.serial_control_reg[SC_RB8] = vote;
                s_d.serial_control_reg[SC_RI] = 1'b1;
              end
            end
          end
        end
      RX_WAIT:
        if (vote_now)
        begin
          s_d.rx_st = RX_HUNT;
        end
      RX_M0_ARM:
        if (s6p2)
        begin
          s_d.rx_sh[7:0] = M0_RX_INIT;
          s_d.rx_st = RX_M0_GO;
        end
      RX_M0_GO:
        s_d.rx_st = RX_M0;
      RX_M0:
      begin
        if (s_q.phase == PH_SAMPLE)
        begin
          s_d.smp[0] = RXD_IN;
        end
        if (s6p2)
        begin
          s_d.rx_sh[7:0] = {s_q.rx_sh[6:0], s_q.smp[0]};
          if (!s_q.rx_sh[7])
          begin
            s_d.serial_buffer = bitrev({s_q.rx_sh[6:0], s_q.smp[0]});
            s_d.rx_st = RX_M0_END;
          end
        end
      end
      RX_M0_END:
        if (s_q.phase == 4'h0)
        begin
          s_d.rx_st = RX_HUNT;
          s_d.serial_control_reg[SC_RI] = 1'b1;
        end
    endcase
    // pins, from the next state so they leave flip-flops aligned
    m0_act = s_d.tx_st inside {TX_M0_SEND, TX_M0_END} || s_d.rx_st inside {RX_M0, RX_M0_END};
    s_d.rxd_oe = s_d.tx_st inside {TX_M0_SEND, TX_M0_END};
    s_d.rxd_o = s_d.tx_sh[0];
    if (m0_act)
    begin
      s_d.txd = !(s_d.phase >= PH_CLK_LO && s_d.phase <= PH_CLK_HI);
    end
    else if (s_d.tx_st == TX_START)
    begin
      s_d.txd = 1'b0;
    end
    else if (s_d.tx_st == TX_DATA)
    begin
      s_d.txd = s_d.tx_sh[0];
    end
    else
    begin
      s_d.txd = 1'b1;
    end
  end

  // timer 1 halving shared by both directions
  function automatic logic rx_tick_t1(input logic t);
    return t;
  endfunction

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      s_q <= '0;
      s_q.serial_control_reg <= REG8_RST;
      s_q.txd <= 1'b1;
      s_q.rx_prev <= 1'b1;
      s_q.timer2_ext_pin_prev <= 1'b1;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready <= 1'b1;
      s_q.rsp.arready <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign AXI_RSP = s_q.rsp;
  assign TXD_OUT = s_q.txd;
  assign RXD_OUT = s_q.rxd_o;
  assign RXD_OE = s_q.rxd_oe;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence m0_rx_loaded;
    s_q.rx_sh[7:0] == M0_RX_INIT ##1 s_q.rx_st == RX_M0;
  endsequence

  sequence tx_m0_done;
    s_q.tx_st == TX_IDLE && s_q.serial_control_reg[SC_TI];
  endsequence

  AST_T2_NOFLAG: assert property (t2_ovf && t2_baud && !timer2_control_reg_wr && !cnt_wr |=>
    s_q.timer2_control_reg[T2_TF] == $past(s_q.timer2_control_reg[T2_TF]) && s_q.t2cnt == $past(s_q.t2rld))
    else $error("baud mode rollover set flag or missed reload");
  AST_T2_RATE: assert property (t2_baud && s_q.timer2_control_reg[T2_RUN] && !cnt_wr && !t2_ovf
    && s_q.phase[0] |=> s_q.t2cnt == $past(s_q.t2cnt) + 16'h1 ##1 $stable(s_q.t2cnt) || cnt_wr)
    else $error("timer 2 not counting once per state time");
  AST_M0_SHCLK: assert property (s_q.tx_st == TX_M0_SEND && s_q.phase >= PH_CLK_LO
    && s_q.phase <= PH_CLK_HI |-> !TXD_OUT && RXD_OE)
    else $error("mode 0 shift clock not low in S3 to S5");
  AST_M0_END: assert property (s_q.tx_st == TX_M0_END && s_q.phase == 4'h0 |=> tx_m0_done)
    else $error("mode 0 send not ended with tx done at S1P1");
  AST_M0_RXLOAD: assert property (s_q.rx_st == RX_M0_ARM && s6p2 |=> m0_rx_loaded)
    else $error("mode 0 receive not loaded and activated");
  AST_RX_EDGE: assert property (s_q.rx_st == RX_HUNT && !m0 && s_q.serial_control_reg[SC_REN] && rx_tick
    && s_q.rx_prev && !RXD_IN |=> s_q.rx_div == 4'h0 && s_q.rx_sh == ASY_RX_INIT)
    else $error("falling edge did not restart receiver");
  AST_RX_FALSE: assert property (s_q.rx_st == RX_BITS && vote_now && vote
    && s_q.rx_sh == ASY_RX_INIT |=> s_q.rx_st == RX_HUNT)
    else $error("false start bit not rejected");
  AST_RX_KEEP: assert property (rx_final && s_q.serial_control_reg[SC_RI] |=> $stable(s_q.serial_buffer))
    else $error("buffer overwritten while rx done set");
  AST_TX_WAIT: assert property (s_q.tx_st == TX_REQ && !tx_roll |=> s_q.tx_st == TX_REQ && TXD_OUT)
    else $error("transmission started off a rollover");
  AST_EXT_EDGE: assert property (timer2_ext_pin_fall && s_q.timer2_control_reg[T2_EXEN] |=> s_q.timer2_control_reg[T2_EXF])
    else $error("external edge not flagged");
endmodule

// file: verification/spfmu_remote.sv
// far-end serial peer: sends frames on the receive pin, catches frames and mode 0 bytes
// assumes the bench sets bit length, frame length and mode 0 use before traffic starts
`timescale 1ns/1ps
module spfmu_remote (
  // clock
  input wire logic clk,
  // pins as the peer sees them
  input wire logic txd,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  output logic rxd_drv,
  // caught frame, one clock pulse
  output logic got,
  output logic [9:0] got_data
);
  int bit_clks = 64;
  int nbits = 10;
  int k;
  int tcnt = 0;
  int rcnt = 0;
  logic sync_mode = 1'b0;
  logic [7:0] m0_src = 8'h00;
  logic [9:0] sh = 10'h0;
  initial
  begin
    rxd_drv = 1'b1;
    got = 1'b0;
    got_data = 10'h0;
  end
  // line is pulled up; a low shorter than a bit is a false start
  task automatic send(input logic [9:0] v, input int n, input int low_clks);
    int i;
    @(posedge clk);
    rxd_drv <= 1'b0;
    repeat (low_clks) @(posedge clk);
    for (i = 0; i < n && low_clks == bit_clks; i++)
    begin
      rxd_drv <= v[i];
      repeat (bit_clks) @(posedge clk);
    end
    rxd_drv <= 1'b1;
  endtask
  always
  begin
    @(txd);
    if (sync_mode)
    begin
      if (rxd_oe && txd)
      begin
        // data is stable across the rising shift clock
        sh = {rxd_out, sh[9:1]};
        tcnt++;
        if (tcnt == 8)
        begin
          tcnt = 0;
          got_data <= {2'b00, sh[9:2]};
          got <= 1'b1;
          @(posedge clk);
          got <= 1'b0;
        end
      end
      else if (!rxd_oe && !txd)
      begin
        rxd_drv <= m0_src[rcnt];
        rcnt++;
      end
      else if (!rxd_oe && rcnt == 8)
      begin
        rxd_drv <= 1'b1;
        rcnt = 0;
      end
    end
    else if (!txd)
    begin
      repeat (bit_clks / 2) @(posedge clk);
      sh = 10'h0;
      for (k = 0; k < nbits; k++)
      begin
        repeat (bit_clks) @(posedge clk);
        sh[k] = txd;
      end
      got_data <= sh;
      got <= 1'b1;
      @(posedge clk);
      got <= 1'b0;
    end
  end
endmodule

// file: verification/tb_serial_port_four_mode_uart.sv
// bench for the four-mode serial port: register bus master, serial peer, result queues
// assumes async modes run 64 clocks a bit, 32 once baud_double is set
`timescale 1ns/1ps
module tb_serial_port_four_mode_uart;
  import spfmu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic timer2_ext_pin = 1'b1;
  logic t1ovf = 1'b0;
  spfmu_axi_req_t req;
  spfmu_axi_rsp_t rsp;
  logic rxd_out, rxd_oe, txd, rxd_drv, got;
  logic [9:0] got_data;
  logic [1:0] wresp;
  logic [31:0] rdata;
  logic [33:0] rd_q[$];
  logic [9:0] ser_q[$];
  int num_errors = 0;
  int comparisons = 0;
  int seed = 57657;
  always #5 clk = ~clk;
  // timer 1 stand-in: one-clock overflow pulse every other clock
  always @(posedge clk)
    t1ovf <= ~t1ovf;
  spfmu_top u_dut (.SYS_CLK(clk), .SYS_RST(rst), .AXI_REQ(req), .AXI_RSP(rsp),
    .RXD_IN(rxd_oe === 1'b1 ? rxd_out : rxd_drv), .RXD_OUT(rxd_out), .RXD_OE(rxd_oe),
    .TXD_OUT(txd), .TIMER2_EXT_PIN_IN(timer2_ext_pin), .T1_OVF_IN(t1ovf));
  spfmu_remote u_rem (.clk(clk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .rxd_drv(rxd_drv), .got(got), .got_data(got_data));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // results are matched to the oldest note as they appear
  always @(posedge clk)
  begin
    if (rsp.rvalid && req.rready && rd_q.size() > 0)
      check({rsp.rresp, rsp.rdata}, rd_q.pop_front());
    if (got)
      check({24'h0, got_data}, {24'h0, ser_q.pop_front()});
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    do
    begin
      @(posedge clk);
      n++;
      if (rsp.awready && req.awvalid)
        req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid)
        req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid && n < 50);
    wresp = rsp.bresp;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] rs, input logic [31:0] e, input logic chk);
    int n;
    n = 0;
    if (chk)
      rd_q.push_back({rs, e});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do
    begin
      @(posedge clk);
      n++;
      if (rsp.arready && req.arvalid)
        req.arvalid <= 1'b0;
    end
    while (!rsp.rvalid && n < 50);
    rdata = rsp.rdata;
    @(posedge clk);
  endtask
  // polls the control register; a bound keeps a stuck flag from hanging the run
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do
    begin
      rd(SERIAL_CONTROL_REG_OFF, RESP_OK, 32'h0, 1'b0);
      n++;
    end
    while (rdata[b] !== 1'b1 && n < 1000);
    if (n >= 1000)
      check(34'h1, 34'h0);
  endtask
  task automatic final_report();
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    logic [7:0] d;
    int j;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(SERIAL_CONTROL_REG_OFF, RESP_OK, 32'h0, 1'b1);
    rd(TIMER2_CONTROL_REG_OFF, RESP_OK, 32'h0, 1'b1);
    rd(8'h18, RESP_ERR, 32'h0, 1'b1);
    wr(8'h1c, 32'hff);
    check({32'h0, wresp}, {32'h0, RESP_ERR});
    for (j = 0; j < 2; j++)
    begin
      d = 8'($random(seed));
      wr(SERIAL_CONTROL_REG_OFF, j ? 32'h88 : 32'h80);
      ser_q.push_back({1'b1, j[0], d});
      wr(SERIAL_BUFFER_OFF, {24'h0, d});
      wr(SERIAL_BUFFER_OFF, {24'h0, ~d});
      wait_flag(SC_TI);
    end
    wr(SERIAL_CONTROL_REG_OFF, 32'h90);
    u_rem.send({2'b10, d}, 10, 64);
    wait_flag(SC_RI);
    u_rem.send({2'b11, ~d}, 10, 64);
    rd(SERIAL_BUFFER_OFF, RESP_OK, {24'h0, d}, 1'b1);
    rd(SERIAL_CONTROL_REG_OFF, RESP_OK, 32'h91, 1'b1);
    for (j = 0; j < 2; j++)
    begin
      wr(SERIAL_CONTROL_REG_OFF, 32'hb0);
      u_rem.send({~j[0], j[0], d ^ 8'h5a}, 10, 64);
      rd(SERIAL_CONTROL_REG_OFF, RESP_OK, j ? 32'hb5 : 32'hb0, 1'b1);
    end
    rd(SERIAL_BUFFER_OFF, RESP_OK, {24'h0, d ^ 8'h5a}, 1'b1);
    wr(SERIAL_CONTROL_REG_OFF, 32'h90);
    u_rem.send(10'h3ff, 10, 12);
    repeat (800) @(posedge clk);
    rd(SERIAL_CONTROL_REG_OFF, RESP_OK, 32'h90, 1'b1);
    wr(TIMER2_CONTROL_REG_OFF, 32'h0);
    wr(T2CNT_OFF, 32'hfffe);
    wr(T2RLD_OFF, 32'hfffe);
    wr(TIMER2_CONTROL_REG_OFF, 32'h34);
    wr(SERIAL_CONTROL_REG_OFF, 32'h50);
    u_rem.nbits = 9;
    d = 8'($random(seed));
    ser_q.push_back({2'b01, d});
    wr(SERIAL_BUFFER_OFF, {24'h0, d});
    wait_flag(SC_TI);
    wr(SERIAL_CONTROL_REG_OFF, 32'h50);
    u_rem.send({2'b01, ~d}, 9, 64);
    wait_flag(SC_RI);
    rd(SERIAL_BUFFER_OFF, RESP_OK, {24'h0, ~d}, 1'b1);
    rd(SERIAL_CONTROL_REG_OFF, RESP_OK, 32'h55, 1'b1);
    wr(SERIAL_CONTROL_REG_OFF, 32'h70);
    u_rem.send({2'b00, d}, 9, 64);
    rd(SERIAL_CONTROL_REG_OFF, RESP_OK, 32'h70, 1'b1);
    rd(TIMER2_CONTROL_REG_OFF, RESP_OK, 32'h34, 1'b1);
    wr(TIMER2_CONTROL_REG_OFF, 32'h3c);
    timer2_ext_pin <= 1'b0;
    repeat (4) @(posedge clk);
    rd(TIMER2_CONTROL_REG_OFF, RESP_OK, 32'h7c, 1'b1);
    // mode 3 on the timer 1 pulse with baud_double: 32 clocks a bit
    wr(TIMER2_CONTROL_REG_OFF, 32'h0);
    wr(POWER_CONTROL_REG_OFF, 32'h80);
    wr(SERIAL_CONTROL_REG_OFF, 32'hc8);
    u_rem.nbits = 10;
    u_rem.bit_clks = 32;
    d = 8'($random(seed));
    ser_q.push_back({2'b11, d});
    wr(SERIAL_BUFFER_OFF, {24'h0, d});
    wait_flag(SC_TI);
    u_rem.sync_mode = 1'b1;
    wr(SERIAL_CONTROL_REG_OFF, 32'h0);
    d = 8'($random(seed));
    ser_q.push_back({2'b00, d});
    wr(SERIAL_BUFFER_OFF, {24'h0, d});
    wait_flag(SC_TI);
    u_rem.m0_src = ~d;
    wr(SERIAL_CONTROL_REG_OFF, 32'h10);
    wait_flag(SC_RI);
    rd(SERIAL_BUFFER_OFF, RESP_OK, {24'h0, ~d}, 1'b1);
    check({24'h0, 10'(ser_q.size())}, 34'h0);
    final_report();
  end
  // whole run is near 8k clocks; this limit of 80k clocks allows ten times that
  initial
  begin
    #800000;
    num_errors++;
    final_report();
  end
endmodule
